/* include/cpr_cfg.svh */
// Register indices, field positions, reset values and timing counts of the regulator
`ifndef CPR_CFG_SVH
`define CPR_CFG_SVH

`define CPR_CLK_MHZ 125
`define CPR_TS_US 1000
`define CPR_TS_CYCLES (`CPR_TS_US * `CPR_CLK_MHZ)
`define CPR_TS_10US 100
`define CPR_TS_MS 1

`define CPR_IDX_CTRL 5'h00
`define CPR_IDX_STATUS 5'h01
`define CPR_IDX_FB_MIN 5'h02
`define CPR_IDX_FB_MAX 5'h03
`define CPR_IDX_REF_MIN 5'h04
`define CPR_IDX_REF_MAX 5'h05
`define CPR_IDX_PRESET 5'h06
`define CPR_IDX_BUS_REF 5'h07
`define CPR_IDX_F_MIN 5'h08
`define CPR_IDX_F_MAX 5'h09
`define CPR_IDX_START_F 5'h0A
`define CPR_IDX_RAMP 5'h0B
`define CPR_IDX_FREQ 5'h0C
`define CPR_IDX_FB_ACT 5'h0D
`define CPR_IDX_REF_ACT 5'h0E
`define CPR_IDX_UNIT 5'h0F
`define CPR_IDX_SPD_SET 5'h10
`define CPR_IDX_PRC_SET 5'h18
`define CPR_OFS_KP 5'h00
`define CPR_OFS_TI 5'h01
`define CPR_OFS_TD 5'h02
`define CPR_OFS_DLIM 5'h03
`define CPR_OFS_FILT 5'h04

`define CPR_CTRL_MODE_LSB 0
`define CPR_CTRL_INV 2
`define CPR_CTRL_AW_DIS 3
`define CPR_CTRL_RUN 4
`define CPR_CTRL_REF_LSB 8
`define CPR_CTRL_FB_LSB 16
`define CPR_REF_CURR 1
`define CPR_FB_CURR 1

`define CPR_MODE_SPEED 2'h1
`define CPR_MODE_PROCESS 2'h3

`define CPR_RST_FB_MAX 32'h000005DC
`define CPR_RST_REF_MAX 32'h000005DC
`define CPR_RST_F_MAX 32'h00000032
`define CPR_RST_RAMP 32'h00000001
`define CPR_RST_KP 32'h0000000A
`define CPR_RST_TI 32'h00002710
`define CPR_RST_TD 32'h000007D0
`define CPR_RST_DLIM 32'h00000032
`define CPR_RST_FILT 32'h00000064

`define CPR_KP_SCALE 64'sh00000000000003E8
`define CPR_KP_MAX 32'sh000003E8
`define CPR_TI_MIN 32'sh000007D0
`define CPR_TI_OFF 32'sh000186A0
`define CPR_TD_MAX 32'sh00004E20
`define CPR_DLIM_MIN 32'sh00000032
`define CPR_DLIM_MAX 32'sh000001F4
`define CPR_DLIM_SCALE 64'sh000000000000000A
`define CPR_FILT_MIN 32'sh00000014
`define CPR_FILT_MAX 32'sh000001F4
`define CPR_REF_FULL 64'sh00000000000003E8
`define CPR_FRAC 8

`endif

/* include/cpr_pkg.sv */
// Types shared by the regulator design
package cpr_pkg;
    typedef enum logic [2:0] {
        CPR_IDLE = 3'b001,
        CPR_RAMP = 3'b010,
        CPR_REG = 3'b100
    } cpr_state_t;
endpackage

/* core/cpr_core.sv */
// Closed-loop PID regulator core with APB register file
//
// Overview of operation
// - Speed mode treats reference and feedback as rpm, ignoring process unit.
// - Summed reference is clamped inside the feedback minimum-to-maximum range.
// - Up to three enabled feedback inputs are added to form the actual value.
// - All active reference sources are summed into the setpoint.
// - Effective reference limits lie inside the feedback limits while the reference and feedback ranges overlap.
// - Reference sum is scaled by maximum reference, floored at minimum reference.
// - With current feedback, the current input is barred as reference.
// - Derivative contribution is limited by a per-regulator gain limit.
// - Feedback lowpass; 0.1 s constant gives 10 rad/s cutoff.
// - Normal direction raises speed when setpoint exceeds feedback.
// - Inverse direction lowers speed when setpoint exceeds feedback.
// - Anti windup reloads integrator with present output frequency at limits.
// - Anti windup on after reset, process regulator may disable it.
// - Ramp to programmed start frequency before process regulation starts.
// - Speed proportional gain 0.000 to 1.000, default 0.010.
// - Integral time from 20.00 ms, default 100 ms, top setting off.
// - Derivative time 0.00 to 200.00 ms, default 20.00 ms.
// - Speed settings apply only when configuration selects speed mode, code 1.
// - Feedback filter is first order, time constant sets cutoff.
// - Zero derivative time disables the term; constant error gives nothing.
// - Derivative gain limit 5.0 to 50.0, default 5.0.
`timescale 1ns/10ps
`include "cpr_cfg.svh"

module cpr_core #(
    parameter int SAMPLE_CYCLES = `CPR_TS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [31:0] ref_volt,
    input wire logic signed [31:0] ref_curr,
    input wire logic signed [31:0] ref_pulse,
    input wire logic signed [31:0] fb_volt,
    input wire logic signed [31:0] fb_curr,
    input wire logic signed [31:0] fb_pulse,
    input wire logic lim_freq_pin,
    input wire logic lim_curr_pin,
    input wire logic lim_volt_pin,
    output logic signed [31:0] freq_cmd,
    output logic freq_strobe,
    output logic reg_active
);

    function automatic logic signed [31:0] clamp32(input logic signed [31:0] x,
                                                   input logic signed [31:0] lo,
                                                   input logic signed [31:0] hi);
        clamp32 = (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction

    function automatic logic signed [31:0] sat64(input logic signed [63:0] x);
        if (x > 64'sh000000007FFFFFFF)
            sat64 = 32'sh7FFFFFFF;
        else if (x < -64'sh0000000080000000)
            sat64 = -32'sh80000000;
        else
            sat64 = x[31:0];
    endfunction

    function automatic logic [31:0] rst_val(input logic [4:0] i);
        logic [2:0] o;
        o = i[2:0];
        rst_val = 32'h00000000;
        if (i == `CPR_IDX_FB_MAX)
            rst_val = `CPR_RST_FB_MAX;
        else if (i == `CPR_IDX_REF_MAX)
            rst_val = `CPR_RST_REF_MAX;
        else if (i == `CPR_IDX_F_MAX)
            rst_val = `CPR_RST_F_MAX;
        else if (i == `CPR_IDX_RAMP)
            rst_val = `CPR_RST_RAMP;
        else if (i[4] == 1'b1) begin
            if (o == 3'(`CPR_OFS_KP))
                rst_val = `CPR_RST_KP;
            else if (o == 3'(`CPR_OFS_TI))
                rst_val = `CPR_RST_TI;
            else if (o == 3'(`CPR_OFS_TD))
                rst_val = `CPR_RST_TD;
            else if (o == 3'(`CPR_OFS_DLIM))
                rst_val = `CPR_RST_DLIM;
            else if (o == 3'(`CPR_OFS_FILT))
                rst_val = `CPR_RST_FILT;
        end
    endfunction

    function automatic logic is_rw(input logic [4:0] i);
        is_rw = (i == `CPR_IDX_CTRL) || (i >= `CPR_IDX_FB_MIN && i <= `CPR_IDX_RAMP) ||
                (i == `CPR_IDX_UNIT) || (i[4] && i[2:0] <= 3'(`CPR_OFS_FILT));
    endfunction

    function automatic logic is_ro(input logic [4:0] i);
        is_ro = (i == `CPR_IDX_STATUS) || (i >= `CPR_IDX_FREQ && i <= `CPR_IDX_REF_ACT);
    endfunction

    logic [31:0] rf_reg [0:31];
    logic [31:0] cnt_reg;
    logic tick;
    logic [2:0] sync1_reg, sync2_reg, sync3_reg, lim_reg;
    cpr_pkg::cpr_state_t state_reg;
    logic signed [31:0] filt_reg, integ_reg, err_prev_reg, ref_act_reg;

    logic [4:0] widx;
    logic map_rw, map_ro, acc;
    assign widx = paddr[6:2];
    assign map_rw = (paddr[31:7] == 25'h0) && (paddr[1:0] == 2'h0) && is_rw(widx);
    assign map_ro = (paddr[31:7] == 25'h0) && (paddr[1:0] == 2'h0) && is_ro(widx);
    assign acc = psel && penable && pready;

    // Configuration fields
    logic [31:0] ctrl;
    logic [1:0] mode;
    logic speed_m, proc_m, closed, run;
    logic [4:0] ref_en;
    logic [2:0] fb_en;
    assign ctrl = rf_reg[`CPR_IDX_CTRL];
    assign mode = ctrl[`CPR_CTRL_MODE_LSB +: 2];
    assign speed_m = (mode == `CPR_MODE_SPEED);
    assign proc_m = (mode == `CPR_MODE_PROCESS);
    assign closed = speed_m || proc_m;
    assign run = ctrl[`CPR_CTRL_RUN] && closed;
    assign fb_en = ctrl[`CPR_CTRL_FB_LSB +: 3];
    // Current input cannot be a reference while it carries feedback
    assign ref_en = ctrl[`CPR_CTRL_REF_LSB +: 5] &
                    ~(5'(fb_en[`CPR_FB_CURR]) << `CPR_REF_CURR);

    // Active gain set: speed set only in speed mode, process set otherwise
    logic [4:0] set_base;
    logic signed [31:0] kp, ti, td, dlim, filt_ms;
    assign set_base = speed_m ? `CPR_IDX_SPD_SET : `CPR_IDX_PRC_SET;
    assign kp = clamp32(rf_reg[set_base + `CPR_OFS_KP], 32'sh0, `CPR_KP_MAX);
    assign ti = clamp32(rf_reg[set_base + `CPR_OFS_TI], `CPR_TI_MIN, `CPR_TI_OFF);
    assign td = clamp32(rf_reg[set_base + `CPR_OFS_TD], 32'sh0, `CPR_TD_MAX);
    assign dlim = clamp32(rf_reg[set_base + `CPR_OFS_DLIM], `CPR_DLIM_MIN,
                          `CPR_DLIM_MAX);
    assign filt_ms = clamp32(rf_reg[set_base + `CPR_OFS_FILT], `CPR_FILT_MIN,
                             `CPR_FILT_MAX);

    // Values are plain rpm in speed mode; the unit word only tags process mode
    logic unit_rpm;
    assign unit_rpm = speed_m;

    // Feedback sum and first-order lowpass, step Ts/Tf per tick
    logic signed [31:0] fb_sum, fb_f, filt_next;
    assign fb_sum = sat64((fb_en[0] ? 64'(fb_volt) : 64'sh0) +
                          (fb_en[1] ? 64'(fb_curr) : 64'sh0) +
                          (fb_en[2] ? 64'(fb_pulse) : 64'sh0));
    assign fb_f = filt_reg >>> `CPR_FRAC;
    assign filt_next = sat64(64'(filt_reg) + ((64'(fb_sum) <<< `CPR_FRAC) - 64'(filt_reg)) *
                             64'(`CPR_TS_MS) / 64'(filt_ms));

    // Reference sum, scaling and limiting
    logic signed [31:0] ref_sum, ref_scaled, eff_min, eff_max, ref_act;
    logic signed [31:0] fb_min, fb_max, ref_min, ref_max;
    assign fb_min = rf_reg[`CPR_IDX_FB_MIN];
    assign fb_max = rf_reg[`CPR_IDX_FB_MAX];
    assign ref_min = rf_reg[`CPR_IDX_REF_MIN];
    assign ref_max = rf_reg[`CPR_IDX_REF_MAX];
    assign ref_sum = sat64((ref_en[0] ? 64'(ref_volt) : 64'sh0) +
                           (ref_en[1] ? 64'(ref_curr) : 64'sh0) +
                           (ref_en[2] ? 64'(ref_pulse) : 64'sh0) +
                           (ref_en[3] ? 64'($signed(rf_reg[`CPR_IDX_PRESET])) : 64'sh0) +
                           (ref_en[4] ? 64'($signed(rf_reg[`CPR_IDX_BUS_REF])) :
                            64'sh0));
    assign ref_scaled = sat64(64'(ref_sum) * 64'(ref_max) / `CPR_REF_FULL);
    assign eff_min = (ref_min > fb_min) ? ref_min : fb_min;
    assign eff_max = (ref_max < fb_max) ? ref_max : fb_max;
    assign ref_act = clamp32(ref_scaled, eff_min, eff_max);

    // Error, direction and PID terms
    logic signed [31:0] err, p_term, dp, d_raw, d_lim, d_term, i_next, pid_sum, f_new;
    logic signed [31:0] f_min, f_max;
    logic sat, aw_on, aw_hit;
    assign f_min = rf_reg[`CPR_IDX_F_MIN];
    assign f_max = rf_reg[`CPR_IDX_F_MAX];
    assign err = ctrl[`CPR_CTRL_INV] ? (fb_f - ref_act) : (ref_act - fb_f);
    assign p_term = sat64(64'(kp) * 64'(err) / `CPR_KP_SCALE);
    assign dp = sat64(64'(kp) * (64'(err) - 64'(err_prev_reg)) / `CPR_KP_SCALE);
    assign d_raw = sat64(64'(dp) * 64'(td) / 64'(`CPR_TS_10US));
    assign d_lim = sat64((dp < 0 ? -64'(dp) : 64'(dp)) * 64'(dlim) / `CPR_DLIM_SCALE);
    assign d_term = (td == 32'sh0) ? 32'sh0 : clamp32(d_raw, -d_lim, d_lim);
    assign i_next = (ti >= `CPR_TI_OFF) ? integ_reg :
                    sat64(64'(integ_reg) + (64'(p_term) <<< `CPR_FRAC) *
                          64'(`CPR_TS_10US) / 64'(ti));
    assign pid_sum = sat64(64'(integ_reg >>> `CPR_FRAC) + 64'(p_term) + 64'(d_term));
    assign f_new = clamp32(pid_sum, f_min, f_max);
    assign sat = (f_new != pid_sum);
    assign aw_on = speed_m || !ctrl[`CPR_CTRL_AW_DIS];
    assign aw_hit = aw_on && (sat || (lim_reg != 3'h0));

    // Start frequency ramp
    logic signed [31:0] start_f, ramp_f;
    assign start_f = clamp32(rf_reg[`CPR_IDX_START_F], f_min, f_max);
    assign ramp_f = sat64(64'(freq_cmd) + 64'($signed(rf_reg[`CPR_IDX_RAMP])));

    // Sample tick
    assign tick = (cnt_reg == 32'(SAMPLE_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_reg <= 32'h0;
        else if (ce)
            cnt_reg <= tick ? 32'h0 : cnt_reg + 32'h1;
    end

    // Limit pins: three stages, a change counts when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
            lim_reg <= 3'h0;
        end else if (ce) begin
            sync1_reg <= {lim_volt_pin, lim_curr_pin, lim_freq_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int b = 0; b < 3; b++) begin
                if (sync2_reg[b] == sync3_reg[b])
                    lim_reg[b] <= sync3_reg[b];
            end
        end
    end

    // APB slave: one wait-free access phase, error on unmapped or read-only write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (ce) begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !(map_rw || (map_ro && !pwrite));
            if (psel && !penable && !pwrite) begin
                if (map_rw)
                    prdata <= rf_reg[widx];
                else if (widx == `CPR_IDX_STATUS && map_ro)
                    prdata <= {24'h0, unit_rpm, lim_reg, 1'b0, state_reg};
                else if (widx == `CPR_IDX_FREQ && map_ro)
                    prdata <= freq_cmd;
                else if (widx == `CPR_IDX_FB_ACT && map_ro)
                    prdata <= fb_f;
                else if (widx == `CPR_IDX_REF_ACT && map_ro)
                    prdata <= ref_act_reg;
                else
                    prdata <= 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 32; i++)
                rf_reg[i] <= rst_val(5'(i));
        end else if (ce && acc && pwrite && map_rw) begin
            rf_reg[widx] <= pwdata;
        end
    end

    // Regulator sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= cpr_pkg::CPR_IDLE;
            freq_cmd <= 32'sh0;
            integ_reg <= 32'sh0;
            filt_reg <= 32'sh0;
            err_prev_reg <= 32'sh0;
            ref_act_reg <= 32'sh0;
            freq_strobe <= 1'b0;
            reg_active <= 1'b0;
        end else if (ce) begin
            freq_strobe <= tick;
            if (tick) begin
                filt_reg <= filt_next;
                ref_act_reg <= ref_act;
                unique case (state_reg)
                    cpr_pkg::CPR_IDLE: begin
                        freq_cmd <= 32'sh0;
                        integ_reg <= 32'sh0;
                        err_prev_reg <= err;
                        if (run && proc_m && start_f > f_min) begin
                            state_reg <= cpr_pkg::CPR_RAMP;
                            freq_cmd <= f_min;
                        end else if (run) begin
                            state_reg <= cpr_pkg::CPR_REG;
                            reg_active <= 1'b1;
                            freq_cmd <= f_min;
                            integ_reg <= f_min <<< `CPR_FRAC;
                        end
                    end
                    cpr_pkg::CPR_RAMP: begin
                        err_prev_reg <= err;
                        if (!run) begin
                            state_reg <= cpr_pkg::CPR_IDLE;
                            freq_cmd <= 32'sh0;
                        end else if (ramp_f >= start_f) begin
                            state_reg <= cpr_pkg::CPR_REG;
                            reg_active <= 1'b1;
                            freq_cmd <= start_f;
                            integ_reg <= start_f <<< `CPR_FRAC;
                        end else begin
                            freq_cmd <= ramp_f;
                        end
                    end
                    cpr_pkg::CPR_REG: begin
                        err_prev_reg <= err;
                        if (!run) begin
                            state_reg <= cpr_pkg::CPR_IDLE;
                            reg_active <= 1'b0;
                            freq_cmd <= 32'sh0;
                            integ_reg <= 32'sh0;
                        end else begin
                            freq_cmd <= f_new;
                            if (aw_hit)
                                integ_reg <= freq_cmd <<< `CPR_FRAC;
                            else
                                integ_reg <= i_next;
                        end
                    end
                    default: begin
                        state_reg <= cpr_pkg::CPR_IDLE;
                        reg_active <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_strobe_tick;
        ce && tick |=> freq_strobe;
    endproperty
    a_strobe_tick: assert property (p_strobe_tick) else $error("no strobe after tick");
    property p_freq_in_limits;
        ce && tick && state_reg == cpr_pkg::CPR_REG && run && f_min <= f_max
            |=> freq_cmd >= $past(f_min) && freq_cmd <= $past(f_max);
    endproperty
    a_freq_in_limits: assert property (p_freq_in_limits) else $error("freq off limits");
    property p_ref_in_fb;
        eff_min <= eff_max |-> ref_act >= fb_min && ref_act <= fb_max;
    endproperty
    a_ref_in_fb: assert property (p_ref_in_fb) else $error("reference off range");
    property p_curr_ref_barred;
        fb_en[`CPR_FB_CURR] |-> !ref_en[`CPR_REF_CURR];
    endproperty
    a_curr_ref_barred: assert property (p_curr_ref_barred) else $error("current ref used");
    property p_td_zero;
        td == 32'sh0 |-> d_term == 32'sh0;
    endproperty
    a_td_zero: assert property (p_td_zero) else $error("derivative active at zero time");
    property p_d_limited;
        d_term <= d_lim && d_term >= -d_lim;
    endproperty
    a_d_limited: assert property (p_d_limited) else $error("derivative over gain limit");
    property p_direction;
        ref_act > fb_f && kp > 32'sh0 |->
            (ctrl[`CPR_CTRL_INV] ? p_term <= 32'sh0 : p_term >= 32'sh0);
    endproperty
    a_direction: assert property (p_direction) else $error("error sign wrong");
    sequence s_aw_tick;
        ce && tick && state_reg == cpr_pkg::CPR_REG && run && aw_hit;
    endsequence
    property p_antiwindup;
        s_aw_tick |=> integ_reg == ($past(freq_cmd) <<< `CPR_FRAC);
    endproperty
    a_antiwindup: assert property (p_antiwindup) else $error("integrator not reloaded");
    sequence s_ramp_done;
        ce && tick && state_reg == cpr_pkg::CPR_RAMP && run && ramp_f >= start_f;
    endsequence
    property p_start_freq;
        s_ramp_done |=> state_reg == cpr_pkg::CPR_REG && freq_cmd == $past(start_f);
    endproperty
    a_start_freq: assert property (p_start_freq) else $error("start ramp end wrong");
    property p_proc_never_skips_ramp;
        ce && tick && state_reg == cpr_pkg::CPR_IDLE && run && proc_m && start_f > f_min
            |=> state_reg == cpr_pkg::CPR_RAMP;
    endproperty
    a_proc_never_skips_ramp: assert property (p_proc_never_skips_ramp)
        else $error("regulation began before start frequency");
endmodule

/* tb/cpr_plant.sv */
// Plant model: motor feedback that follows the output frequency command
`timescale 1ns/10ps
module cpr_plant (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic signed [31:0] freq_cmd,
    input wire logic freq_strobe,
    output logic signed [31:0] fb_volt,
    output logic signed [31:0] fb_curr
);
    // Speed settles one sample late; both transducers stay below the lowest setpoint
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_volt <= 32'sh0;
            fb_curr <= 32'sh0;
        end else if (freq_strobe) begin
            fb_volt <= freq_cmd;
            fb_curr <= freq_cmd >>> 2;
        end
    end
endmodule

/* tb/closed_loop_pid_regulator_tb.sv */
// Self-checking bench of the regulator core
`timescale 1ns/10ps
module closed_loop_pid_regulator_tb;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic freq_strobe, reg_active, lim_f, lim_c, lim_v;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic signed [31:0] ref_volt, ref_curr, ref_pulse, fb_volt, fb_curr, fb_pulse, freq_cmd;
    int mismatches = 0, n_tests = 0, cyc = 0, i, pr, br;
    int q[$];
    int ra[11] = '{'h00, 'h0C, 'h14, 'h24, 'h28, 'h2C, 'h40, 'h44, 'h48, 'h4C, 'h50};
    int rv[11] = '{0, 1500, 1500, 50, 0, 1, 10, 10000, 2000, 50, 100};
    int ca[5] = '{'h40, 'h44, 'h48, 'h4C, 'h50};
    int cw[5] = '{2000, 5, 30000, 10, 1000};
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    cpr_core #(.SAMPLE_CYCLES(40)) cpr_core_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_volt(ref_volt),
        .ref_curr(ref_curr), .ref_pulse(ref_pulse), .fb_volt(fb_volt), .fb_curr(fb_curr),
        .fb_pulse(fb_pulse), .lim_freq_pin(lim_f), .lim_curr_pin(lim_c),
        .lim_volt_pin(lim_v), .freq_cmd(freq_cmd), .freq_strobe(freq_strobe),
        .reg_active(reg_active));
    cpr_plant cpr_plant_i (.pclk(pclk), .presetn(presetn), .freq_cmd(freq_cmd),
        .freq_strobe(freq_strobe), .fb_volt(fb_volt), .fb_curr(fb_curr));
    task close_out;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", nm, ex, got);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask
    // First strobe that carries a nonzero command; an idle tick shows zero
    task wait_cmd;
        @(posedge pclk);
        while (freq_strobe !== 1'b1 || freq_cmd === 32'sh0) @(posedge pclk);
    endtask
    // Reference model: sum, scale by maximum reference, clamp into both ranges
    function automatic int ref_model(int v[$], int rmin, int rmax, int fmin, int fmax);
        int s = 0;
        foreach (v[k]) s += v[k];
        s = s * rmax / 1000;
        if (s < ((rmin > fmin) ? rmin : fmin)) s = (rmin > fmin) ? rmin : fmin;
        if (s > ((rmax < fmax) ? rmax : fmax)) s = (rmax < fmax) ? rmax : fmax;
        return s;
    endfunction
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            close_out();
        end
    end
    always @(posedge pclk)
        if (freq_strobe === 1'b1 && reg_active === 1'b1)
            chk("freq_range", 32'h1, {31'h0, freq_cmd >= 5 && freq_cmd <= 50});
    initial begin
        presetn = 1'b0;
        {ce, psel, penable, pwrite, lim_f, lim_c, lim_v} = 7'h40;
        {paddr, pwdata, ref_volt, ref_curr, ref_pulse, fb_pulse} = '0;
        void'($urandom(2030));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 11; i++) rchk("reset_value", ra[i], rv[i]);
        apb(1'b1, 'h30, 32'h1);
        chk("ro_write_err", 32'h1, {31'h0, er});
        apb(1'b0, 'h54, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        apb(1'b0, 'h02, 32'h0);
        chk("misaligned_err", 32'h1, {31'h0, er});
        for (i = 0; i < 5; i++) begin
            apb(1'b1, ca[i], cw[i]);
            rchk("setting_readback", ca[i], cw[i]);
        end
        ref_volt <= $urandom_range(400, 100);
        ref_curr <= $urandom_range(400, 1);
        ref_pulse <= $urandom_range(300, 0);
        pr = $urandom_range(200, 0);
        br = $urandom_range(200, 0);
        apb(1'b1, 'h0C, 32'd1000);
        apb(1'b1, 'h10, 32'd100);
        apb(1'b1, 'h14, 32'd1200);
        apb(1'b1, 'h18, pr);
        apb(1'b1, 'h1C, br);
        apb(1'b1, 'h20, 32'd5);
        apb(1'b1, 'h00, 32'h00031F01);
        repeat (120) @(posedge pclk);
        q = {ref_volt, ref_pulse, pr, br};
        rchk("ref_act", 'h38, ref_model(q, 100, 1200, 0, 1000));
        apb(1'b1, 'h00, 32'h00031F11);
        wait_cmd();
        chk("start_freq", 32'd5, freq_cmd);
        chk("active", 32'h1, {31'h0, reg_active});
        repeat (400) @(posedge pclk);
        chk("normal_dir", 32'd50, freq_cmd);
        apb(1'b1, 'h00, 32'h00031F15);
        repeat (400) @(posedge pclk);
        chk("inverse_dir", 32'd5, freq_cmd);
        apb(1'b1, 'h00, 32'h00031F01);
        repeat (120) @(posedge pclk);
        chk("stopped", 32'd0, freq_cmd);
        chk("idle", 32'h0, {31'h0, reg_active});
        lim_c <= 1'b1;
        repeat (6) @(posedge pclk);
        rchk("status_speed", 'h04, 32'hA1);
        apb(1'b1, 'h28, 32'd20);
        apb(1'b1, 'h2C, 32'd5);
        apb(1'b1, 'h00, 32'h00031F13);
        wait_cmd();
        chk("ramp_first", 32'd5, freq_cmd);
        chk("ramp_inactive", 32'h0, {31'h0, reg_active});
        while (reg_active !== 1'b1) @(posedge pclk);
        chk("proc_start", 32'd20, freq_cmd);
        rchk("status_proc", 'h04, 32'h24);
        close_out();
    end
endmodule
